// file: src/pio_top.sv
/*
  Parallel I/O port block with APB register access.
  Assumes pins arrive asynchronous; alternate function and bus
  controller signals arrive on clk.
*/
// Behaviour
// (R01) 79 lines: six bidirectional ports, one input-only
// (R02) Single-bit set, clear and read per line
// (R03) Per-line direction bit selects input or output
// (R04) Input direction disables driver, pin floats
// (R05) Per-pin push/pull or open-drain on some ports
// (R06) Reset forces inputs except reset indication output
// (R07) Software selects pad edge shape and drive
// (R08) Per-byte TTL or hysteresis input threshold
// (R09) Unused alternate function leaves plain GPIO
// (R10) Port 0 address/data; demux uses Port 1
// (R11) Port 4 segment lines above 64K, chip selects
// (R12) Port 20 bus strobes, access enable, reset indication
// (R13) CAN lines routed to Port 4 or Port 9
// (R14) Output without alternate function drives data latch
module pio_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic [15:0] p0_in,
  output logic      [15:0] p0_out,
  output logic      [15:0] p0_oe,
  input  wire logic [15:0] p1_in,
  output logic      [15:0] p1_out,
  output logic      [15:0] p1_oe,
  input  wire logic [14:0] p3_in,
  output logic      [14:0] p3_out,
  output logic      [14:0] p3_oe,
  input  wire logic [7:0]  p4_in,
  output logic      [7:0]  p4_out,
  output logic      [7:0]  p4_oe,
  input  wire logic [13:0] p5_in,
  input  wire logic [4:0]  p9_in,
  output logic      [4:0]  p9_out,
  output logic      [4:0]  p9_oe,
  input  wire logic [4:0]  p20_in,
  output logic      [4:0]  p20_out,
  output logic      [4:0]  p20_oe,
  // Pad settings
  output logic      [27:0] pad_output_control,
  output logic      [5:0]  input_threshold,
  // External bus controller
  input  wire logic        ebc_active,
  input  wire logic        ebc_mux,
  input  wire logic        ebc_addr_phase,
  input  wire logic [15:0] ebc_addr,
  input  wire logic [15:0] ebc_wdata,
  input  wire logic        ebc_wdata_oe,
  input  wire logic        ebc_seg_en,
  input  wire logic [7:0]  ebc_seg,
  input  wire logic [3:0]  ebc_cs_n,
  input  wire logic        ebc_rd_n,
  input  wire logic        write_strobe_low_n,
  input  wire logic        ebc_ale,
  input  wire logic        reset_request,
  output logic             external_access_enable,
  // Peripheral alternate functions
  input  wire logic [14:0] p3_alt_out,
  input  wire logic [14:0] p3_alt_oe,
  input  wire logic [4:0]  p9_alt_out,
  input  wire logic [4:0]  p9_alt_oe,
  input  wire logic [1:0]  can_tx,
  output logic      [1:0]  can_rx,
  output logic [6:0][15:0] pin_state
);

  typedef struct packed {
    logic [6:0][15:0] data;
    logic [6:0][15:0] dir;
    logic [6:0][15:0] od;
    logic [6:0][15:0] alt;
    logic [6:0][15:0] sync1;
    logic [6:0][15:0] sync2;
    logic [6:0][15:0] pad_out;
    logic [6:0][15:0] pad_oe;
    logic [6:0][7:0]  pad;
    logic [2:0]       ctrl;
    logic [1:0]       can_rx;
    logic             ext_access;
    pio_pkg::pio_apb_t apb;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } pio_state_t;

  pio_state_t       st_reg;
  pio_state_t       st_next;
  logic [6:0][15:0] pin_raw;
  logic [6:0][15:0] alt_en;
  logic [6:0][15:0] alt_out;
  logic [6:0][15:0] alt_oe;
  logic [6:0][15:0] cell_out;
  logic [6:0][15:0] cell_oe;
  logic             can_on;
  logic             can_p9;

  //////////////////////////////////////////////////////////////////////
  // Address decode helpers

  function automatic logic addr_ok(input logic [11:0] a, input logic wr);
    logic ok;
    ok = 1'b0;
    if (a == pio_pkg::CTRL_ADDR) begin
      ok = 1'b1;
    end else if (a[11:8] == 4'h0 && a[1:0] == 2'h0 && a[7:5] != 3'h7) begin
      ok = !(wr && a[4:2] == pio_pkg::SEL_PIN);
    end
    return ok;
  endfunction

  function automatic logic [15:0] port_read(input pio_state_t s,
                                            input logic [11:0] a);
    logic [2:0]  p;
    logic [2:0]  r;
    logic [15:0] v;
    p = a[7:5];
    r = a[4:2];
    v = 16'h0000;
    if (r == pio_pkg::SEL_DATA) begin
      v = s.data[p];
    end else if (r == pio_pkg::SEL_DIR) begin
      v = s.dir[p];
    end else if (r == pio_pkg::SEL_OD) begin
      v = s.od[p];
    end else if (r == pio_pkg::SEL_PIN) begin
      v = s.sync2[p];                                // (R02)
    end else if (r == pio_pkg::SEL_ALT) begin
      v = s.alt[p];
    end else if (r == pio_pkg::SEL_PAD) begin
      v = {8'h00, s.pad[p]};
    end
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin gathering and alternate function ownership

  always_comb begin
    pin_raw = '0;
    pin_raw[pio_pkg::P0] = p0_in;
    pin_raw[pio_pkg::P1] = p1_in;
    pin_raw[pio_pkg::P3][pio_pkg::P3_W-1:0] = p3_in;
    pin_raw[pio_pkg::P4][pio_pkg::P4_W-1:0] = p4_in;
    pin_raw[pio_pkg::P5][pio_pkg::P5_W-1:0] = p5_in;   // (R01)
    pin_raw[pio_pkg::P9][pio_pkg::P9_W-1:0] = p9_in;
    pin_raw[pio_pkg::P20][pio_pkg::P20_W-1:0] = p20_in;
  end

  assign can_on = st_reg.ctrl[pio_pkg::CTRL_CAN_EN];
  assign can_p9 = st_reg.ctrl[pio_pkg::CTRL_CAN_ROUTE];

  always_comb begin
    alt_en  = '0;
    alt_out = '0;
    alt_oe  = '0;
    // Bus owns Port 0 for every external cycle
    alt_en[pio_pkg::P0] = {16{ebc_active}};                  // (R10)
    alt_out[pio_pkg::P0] = (ebc_mux && ebc_addr_phase) ?
                           ebc_addr : ebc_wdata;             // (R10)
    alt_oe[pio_pkg::P0] = {16{(ebc_mux && ebc_addr_phase) ||
                              ebc_wdata_oe}};
    alt_en[pio_pkg::P1] = {16{ebc_active && !ebc_mux}};      // (R10)
    alt_out[pio_pkg::P1] = ebc_addr;
    alt_oe[pio_pkg::P1] = 16'hFFFF;
    alt_en[pio_pkg::P3] = st_reg.alt[pio_pkg::P3];           // (R09)
    alt_out[pio_pkg::P3][pio_pkg::P3_W-1:0] = p3_alt_out;
    alt_oe[pio_pkg::P3][pio_pkg::P3_W-1:0] = p3_alt_oe;
    // Port 4: segment lines, then chip selects, then CAN on top
    if (ebc_active && ebc_seg_en) begin                      // (R11)
      alt_en[pio_pkg::P4][7:0] = 8'hFF;
      alt_out[pio_pkg::P4][7:0] = ebc_seg;
      alt_oe[pio_pkg::P4][7:0] = 8'hFF;
    end
    if (st_reg.ctrl[pio_pkg::CTRL_CS_EN]) begin              // (R11)
      alt_en[pio_pkg::P4][7:4] = 4'hF;
      alt_out[pio_pkg::P4][7:4] = ebc_cs_n;
      alt_oe[pio_pkg::P4][7:4] = 4'hF;
    end
    alt_en[pio_pkg::P9] = st_reg.alt[pio_pkg::P9];
    alt_out[pio_pkg::P9][pio_pkg::P9_W-1:0] = p9_alt_out;
    alt_oe[pio_pkg::P9][pio_pkg::P9_W-1:0] = p9_alt_oe;
    if (can_on && !can_p9) begin                             // (R13)
      alt_en[pio_pkg::P4][7:4] = 4'hF;
      alt_out[pio_pkg::P4][7:4] = {can_tx[1], 1'b1, can_tx[0], 1'b1};
      alt_oe[pio_pkg::P4][7:4] = 4'hA;
    end else if (can_on) begin                               // (R13)
      alt_en[pio_pkg::P9][3:0] = 4'hF;
      alt_out[pio_pkg::P9][3:0] = {can_tx[1], 1'b1, can_tx[0], 1'b1};
      alt_oe[pio_pkg::P9][3:0] = 4'hA;
    end
    // Port 20 strobes; access enable is input only
    alt_en[pio_pkg::P20][pio_pkg::P20_RD]  = ebc_active;     // (R12)
    alt_en[pio_pkg::P20][pio_pkg::P20_WR]  = ebc_active;
    alt_en[pio_pkg::P20][pio_pkg::P20_ALE] = ebc_active;
    alt_out[pio_pkg::P20][pio_pkg::P20_RD]  = ebc_rd_n;
    alt_out[pio_pkg::P20][pio_pkg::P20_WR]  = write_strobe_low_n;
    alt_out[pio_pkg::P20][pio_pkg::P20_ALE] = ebc_ale;
    alt_oe[pio_pkg::P20][pio_pkg::P20_ALE:pio_pkg::P20_RD] = 3'h7;
    alt_en[pio_pkg::P20][pio_pkg::P20_EA]   = 1'b1;          // (R12)
    alt_en[pio_pkg::P20][pio_pkg::P20_RSTO] = 1'b1;
    alt_out[pio_pkg::P20][pio_pkg::P20_RSTO] = !reset_request;
    alt_oe[pio_pkg::P20][pio_pkg::P20_RSTO]  = 1'b1;
  end

  genvar gi;
  for (gi = 0; gi < pio_pkg::NPORT; gi++) begin : g_cell
    pio_pad_cell u_cell (
      .latch    (st_reg.data[gi]),
      .dir      (st_reg.dir[gi]),
      .od       (st_reg.od[gi]),
      .alt_en   (alt_en[gi]),
      .alt_out  (alt_out[gi]),
      .alt_oe   (alt_oe[gi]),
      .pin_mask (pio_pkg::PIN_MASK[gi]),
      .pad_out  (cell_out[gi]),
      .pad_oe   (cell_oe[gi])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [2:0]  p;
    logic [2:0]  r;
    logic [15:0] w;
    st_next = st_reg;
    p = paddr[7:5];
    r = paddr[4:2];
    w = pwdata[15:0] & pio_pkg::PIN_MASK[p];
    st_next.sync1 = pin_raw;
    st_next.sync2 = st_reg.sync1;
    st_next.pad_out = cell_out;
    st_next.pad_oe = cell_oe;
    st_next.ext_access = st_reg.sync2[pio_pkg::P20][pio_pkg::P20_EA];
    if (!can_on) begin
      st_next.can_rx = pio_pkg::CAN_IDLE;
    end else if (can_p9) begin
      st_next.can_rx = {st_reg.sync2[pio_pkg::P9][pio_pkg::CAN_RX1],
                        st_reg.sync2[pio_pkg::P9][pio_pkg::CAN_RX0]};
    end else begin
      st_next.can_rx = {
        st_reg.sync2[pio_pkg::P4][pio_pkg::P4_CAN_BASE+pio_pkg::CAN_RX1],
        st_reg.sync2[pio_pkg::P4][pio_pkg::P4_CAN_BASE+pio_pkg::CAN_RX0]};
    end
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // One wait state: answer registered, write lands on the edge after pready rises
    case (st_reg.apb)
      pio_pkg::PIO_IDLE: begin
        if (psel && penable) begin
          st_next.apb = pio_pkg::PIO_DONE;
          st_next.pready = 1'b1;
          st_next.pslverr = !addr_ok(paddr, pwrite);
          if (pwrite || !addr_ok(paddr, pwrite)) begin
            st_next.prdata = 32'h0000_0000;
          end else if (paddr == pio_pkg::CTRL_ADDR) begin
            st_next.prdata = {29'h0000_0000, st_reg.ctrl};
          end else begin
            st_next.prdata = {16'h0000, port_read(st_reg, paddr)};
          end
        end
      end
      pio_pkg::PIO_DONE: begin
        st_next.apb = pio_pkg::PIO_IDLE;
        if (pwrite && !st_reg.pslverr) begin
          if (paddr == pio_pkg::CTRL_ADDR) begin
            st_next.ctrl = pwdata[2:0];                      // (R13)
          end else if (r == pio_pkg::SEL_DATA) begin
            st_next.data[p] = w;
          end else if (r == pio_pkg::SEL_SET) begin
            st_next.data[p] = st_reg.data[p] | w;            // (R02)
          end else if (r == pio_pkg::SEL_CLR) begin
            st_next.data[p] = st_reg.data[p] & ~w;           // (R02)
          end else if (r == pio_pkg::SEL_DIR) begin
            st_next.dir[p] = w & pio_pkg::DIR_MASK[p];       // (R03)
          end else if (r == pio_pkg::SEL_OD) begin
            st_next.od[p] = w & pio_pkg::OD_MASK[p];         // (R05)
          end else if (r == pio_pkg::SEL_ALT) begin
            st_next.alt[p] = w;
          end else if (r == pio_pkg::SEL_PAD) begin
            st_next.pad[p] = pwdata[7:0] &
                             pio_pkg::PAD_MASK[p];           // (R07) (R08)
          end
        end
      end
      default: st_next.apb = pio_pkg::PIO_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;                                          // (R06)
      st_reg.pad_oe <= pio_pkg::OE_RST;                      // (R06)
      st_reg.ctrl <= pio_pkg::CTRL_RST;
      st_reg.can_rx <= pio_pkg::CAN_IDLE;
      st_reg.apb <= pio_pkg::PIO_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign p0_out  = st_reg.pad_out[pio_pkg::P0];
  assign p0_oe   = st_reg.pad_oe[pio_pkg::P0];
  assign p1_out  = st_reg.pad_out[pio_pkg::P1];
  assign p1_oe   = st_reg.pad_oe[pio_pkg::P1];
  assign p3_out  = st_reg.pad_out[pio_pkg::P3][pio_pkg::P3_W-1:0];
  assign p3_oe   = st_reg.pad_oe[pio_pkg::P3][pio_pkg::P3_W-1:0];
  assign p4_out  = st_reg.pad_out[pio_pkg::P4][pio_pkg::P4_W-1:0];
  assign p4_oe   = st_reg.pad_oe[pio_pkg::P4][pio_pkg::P4_W-1:0];
  assign p9_out  = st_reg.pad_out[pio_pkg::P9][pio_pkg::P9_W-1:0];
  assign p9_oe   = st_reg.pad_oe[pio_pkg::P9][pio_pkg::P9_W-1:0];
  assign p20_out = st_reg.pad_out[pio_pkg::P20][pio_pkg::P20_W-1:0];
  assign p20_oe  = st_reg.pad_oe[pio_pkg::P20][pio_pkg::P20_W-1:0];
  assign pad_output_control = {st_reg.pad[6][3:0], st_reg.pad[5][3:0],
    st_reg.pad[4][3:0], st_reg.pad[3][3:0], st_reg.pad[2][3:0],
    st_reg.pad[1][3:0], st_reg.pad[0][3:0]};                 // (R07)
  assign input_threshold = {
    st_reg.pad[pio_pkg::P9][pio_pkg::PAD_THR_LSB +: 2],
    st_reg.pad[pio_pkg::P4][pio_pkg::PAD_THR_LSB +: 2],
    st_reg.pad[pio_pkg::P3][pio_pkg::PAD_THR_LSB +: 2]};     // (R08)
  assign external_access_enable = st_reg.ext_access;
  assign can_rx    = st_reg.can_rx;
  assign pin_state = st_reg.sync2;

endmodule

// file: src/pio_pkg.sv
/*
  Constants of the parallel port block: port indices, pin masks,
  register offsets and field positions.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package pio_pkg;

  localparam int NPORT = 7;
  localparam int PW    = 16;

  // Port indices inside the block
  localparam logic [2:0] P0  = 3'h0;
  localparam logic [2:0] P1  = 3'h1;
  localparam logic [2:0] P3  = 3'h2;
  localparam logic [2:0] P4  = 3'h3;
  localparam logic [2:0] P5  = 3'h4;
  localparam logic [2:0] P9  = 3'h5;
  localparam logic [2:0] P20 = 3'h6;

  // Pin counts: 16+16+15+8+14+5+5 = 79
  localparam int P3_W  = 15;
  localparam int P4_W  = 8;
  localparam int P5_W  = 14;
  localparam int P9_W  = 5;
  localparam int P20_W = 5;

  // Index 6 (P20) first
  localparam logic [6:0][15:0] PIN_MASK = {16'h001F, 16'h001F, 16'h3FFF,
    16'h00FF, 16'h7FFF, 16'hFFFF, 16'hFFFF};
  localparam logic [6:0][15:0] DIR_MASK = {16'h001F, 16'h001F, 16'h0000,
    16'h00FF, 16'h7FFF, 16'hFFFF, 16'hFFFF};
  localparam logic [6:0][15:0] OD_MASK  = {16'h001F, 16'h001F, 16'h0000,
    16'h00FF, 16'h7FFF, 16'h0000, 16'h0000};
  localparam logic [6:0][7:0]  PAD_MASK = {8'h0F, 8'h3F, 8'h00, 8'h3F,
    8'h3F, 8'h0F, 8'h0F};

  // Register offsets within a port block
  localparam logic [2:0] SEL_DATA = 3'h0;
  localparam logic [2:0] SEL_SET  = 3'h1;
  localparam logic [2:0] SEL_CLR  = 3'h2;
  localparam logic [2:0] SEL_DIR  = 3'h3;
  localparam logic [2:0] SEL_OD   = 3'h4;
  localparam logic [2:0] SEL_PIN  = 3'h5;
  localparam logic [2:0] SEL_ALT  = 3'h6;
  localparam logic [2:0] SEL_PAD  = 3'h7;
  localparam logic [11:0] CTRL_ADDR = 12'h100;

  // Pad control fields
  localparam int PAD_EDGE_LSB = 0;
  localparam int PAD_DRV_LSB  = 2;
  localparam int PAD_THR_LSB  = 4;

  // Global control bits
  localparam int CTRL_CAN_ROUTE = 0;
  localparam int CTRL_CAN_EN    = 1;
  localparam int CTRL_CS_EN     = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Pin positions of alternate functions
  localparam int CAN_RX0 = 0;
  localparam int CAN_TX0 = 1;
  localparam int CAN_RX1 = 2;
  localparam int CAN_TX1 = 3;
  localparam int P4_CAN_BASE = 4;
  localparam int P20_RD   = 0;
  localparam int P20_WR   = 1;
  localparam int P20_ALE  = 2;
  localparam int P20_EA   = 3;
  localparam int P20_RSTO = 4;

  localparam logic [6:0][15:0] OE_RST = {16'h0010, {6{16'h0000}}};
  localparam logic [1:0] CAN_IDLE = 2'h3;

  typedef enum {PIO_IDLE, PIO_DONE} pio_apb_t;

endpackage

// file: src/pio_pad_cell.sv
/*
  One port's pad driver selection: alternate function or GPIO latch,
  push/pull or open-drain.
  Assumes all inputs are on the clk domain; result is registered above.
*/
module pio_pad_cell (
  input  wire logic [15:0] latch,
  input  wire logic [15:0] dir,
  input  wire logic [15:0] od,
  input  wire logic [15:0] alt_en,
  input  wire logic [15:0] alt_out,
  input  wire logic [15:0] alt_oe,
  input  wire logic [15:0] pin_mask,
  output logic      [15:0] pad_out,
  output logic      [15:0] pad_oe
);

  logic [15:0] drv;
  logic [15:0] val;

  always_comb begin
    drv = (alt_en & alt_oe) | (~alt_en & dir);       // (R03) (R09)
    val = (alt_en & alt_out) | (~alt_en & latch);    // (R14)
    // Open drain: only a low is driven
    pad_oe  = drv & pin_mask & ~(od & val);          // (R04) (R05)
    pad_out = val & ~od;                             // (R05)
  end

endmodule

// file: tb/pio_monitor.sv
/*
  Checker of reset, APB answer and bus pin timing for pio_top.
  Assumes one clk domain, rst_n async active low; bound below.
*/
module pio_monitor (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [15:0]      p0_in,
  input wire logic [15:0]      p0_out,
  input wire logic [15:0]      p0_oe,
  input wire logic [15:0]      p1_out,
  input wire logic [15:0]      p1_oe,
  input wire logic [4:0]       p20_out,
  input wire logic [4:0]       p20_oe,
  input wire logic             ebc_active,
  input wire logic             ebc_mux,
  input wire logic             ebc_addr_phase,
  input wire logic [15:0]      ebc_addr,
  input wire logic [15:0]      ebc_wdata,
  input wire logic             ebc_wdata_oe,
  input wire logic             reset_request,
  input wire logic [6:0][15:0] pin_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  // Sampled reset, so the edge that asserts it is not judged
  AST_RST_INPUTS: assert property (disable iff (1'b0)
    !rst_n |-> p0_oe == 16'h0 && p20_oe == 5'h10 && !p20_out[4])
    else $error("pins driven in reset");
  AST_PREADY_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  AST_REFUSE_MISALIGN: assert property (
    psel && penable && !pready && paddr[1:0] != 2'h0
    |=> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  AST_RESET_INDICATION: assert property (
    reset_request |=> p20_oe[4] && !p20_out[4])
    else $error("reset indication not low");
  AST_ACCESS_INPUT: assert property (!p20_oe[3])
    else $error("access enable pin driven");
  AST_MUX_ADDR: assert property (
    ebc_active && ebc_mux && ebc_addr_phase
    |=> p0_oe == 16'hFFFF && p0_out == $past(ebc_addr))
    else $error("port 0 address wrong");
  AST_BUS_DATA: assert property (
    ebc_active && ebc_wdata_oe && !ebc_addr_phase
    |=> p0_oe == 16'hFFFF && p0_out == $past(ebc_wdata))
    else $error("port 0 data wrong");
  AST_DEMUX_ADDR: assert property (
    ebc_active && !ebc_mux
    |=> p1_oe == 16'hFFFF && p1_out == $past(ebc_addr))
    else $error("port 1 address wrong");
  // Four stable samples cover the two sync stages after a reset
  AST_PIN_SYNC: assert property (
    $stable(p0_in) [*4] |-> pin_state[0] == p0_in)
    else $error("pin state lags input");
endmodule

bind pio_top pio_monitor u_mon (.clk, .rst_n, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .p0_in, .p0_out, .p0_oe, .p1_out, .p1_oe,
  .p20_out, .p20_oe, .ebc_active, .ebc_mux, .ebc_addr_phase, .ebc_addr,
  .ebc_wdata, .ebc_wdata_oe, .reset_request, .pin_state);

// file: tb/pio_board.sv
/*
  Board side of one port: pull-ups and an external driver per line.
  Assumes the external driver is only enabled on released lines.
*/
module pio_board #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] drv_out,
  input  wire logic [W-1:0] drv_oe,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released or open-drain high lines read ext_val where ext_en is set, else the pull-up level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin[i] = drv_oe[i] ? drv_out[i] :
               (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

// file: tb/tb_top.sv
/*
  Testbench of pio_top: APB tasks, pin and bus scenarios.
  Assumes the board model pio_board and the bound checker.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, got_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, got;
  logic [15:0] p0_in, p0_out, p0_oe, p1_out, p1_oe, p1_in = 16'h0;
  logic [15:0] p0_ext = 16'h5A00, p0_ext_en = 16'hFF00;
  logic [15:0] ebc_addr = 16'h0, ebc_wdata = 16'h0;
  logic [14:0] p3_out, p3_oe, p3_in = 15'h0, p3_alt_out = 15'h0;
  logic [14:0] p3_alt_oe = 15'h1;
  logic [7:0]  p4_in, p4_out, p4_oe, p4_ext = 8'h0, p4_ext_en = 8'h0;
  logic [7:0]  ebc_seg = 8'h0;
  logic [13:0] p5_in = 14'h2AAA;
  logic [4:0]  p9_out, p9_oe, p20_out, p20_oe, p9_in = 5'h04;
  logic [4:0]  p9_alt_out = 5'h0, p9_alt_oe = 5'h0, p20_in = 5'h00;
  logic [27:0] pad_output_control;
  logic [5:0]  input_threshold;
  logic        ebc_active = 1'b0, ebc_mux = 1'b0, ebc_addr_phase = 1'b0;
  logic        ebc_wdata_oe = 1'b0, ebc_seg_en = 1'b0, ebc_rd_n = 1'b1;
  logic        write_strobe_low_n = 1'b1, ebc_ale = 1'b0;
  logic        reset_request = 1'b0, external_access_enable;
  logic [3:0]  ebc_cs_n = 4'hF;
  logic [1:0]  can_tx = 2'h2, can_rx;
  logic [6:0][15:0] pin_state;
  int          mismatches = 0, check_count = 0;

  pio_top dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .p0_in, .p0_out, .p0_oe, .p1_in, .p1_out,
    .p1_oe, .p3_in, .p3_out, .p3_oe, .p4_in, .p4_out, .p4_oe, .p5_in, .p9_in,
    .p9_out, .p9_oe, .p20_in, .p20_out, .p20_oe, .pad_output_control,
    .input_threshold, .ebc_active, .ebc_mux, .ebc_addr_phase, .ebc_addr,
    .ebc_wdata, .ebc_wdata_oe, .ebc_seg_en, .ebc_seg, .ebc_cs_n, .ebc_rd_n,
    .write_strobe_low_n, .ebc_ale, .reset_request, .external_access_enable,
    .p3_alt_out, .p3_alt_oe, .p9_alt_out, .p9_alt_oe, .can_tx, .can_rx,
    .pin_state);
  pio_board #(.W(16)) board0 (.drv_out(p0_out), .drv_oe(p0_oe),
    .ext_val(p0_ext), .ext_en(p0_ext_en), .pin(p0_in));
  pio_board #(.W(8)) board4 (.drv_out(p4_out), .drv_oe(p4_oe),
    .ext_val(p4_ext), .ext_en(p4_ext_en), .pin(p4_in));

  always #25 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Answer taken at the edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    got = prdata;
    got_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    wt(20000);
    mismatches++;
    final_report();
  end

  initial begin
    // A real falling edge, so the async reset acts before the first clock
    rst_n <= 1'b0;
    wt(4);
    chk(32'(p20_oe), 32'h10);
    chk(32'(p0_oe | p1_oe | p4_oe), 32'h0);
    rst_n <= 1'b1;
    apb(1'b1, 12'h000, 32'hA5A5);
    apb(1'b1, 12'h00C, 32'h00FF);
    wt(2);
    chk(32'(p0_oe), 32'h00FF);
    chk(32'(p0_out & p0_oe), 32'h00A5);
    apb(1'b1, 12'h004, 32'h0200);
    apb(1'b1, 12'h008, 32'h0005);
    apb(1'b0, 12'h000, 32'h0);
    chk(got, 32'hA7A0);
    apb(1'b0, 12'h014, 32'h0);
    chk(got, 32'h5AA0);
    apb(1'b0, 12'h004, 32'h0);
    chk(got, 32'h0);
    $display("test gpio done");
    apb(1'b1, 12'h060, 32'h35);
    apb(1'b1, 12'h06C, 32'hFF);
    apb(1'b1, 12'h070, 32'h0F);
    wt(2);
    chk(32'(p4_oe), 32'hFA);
    chk(32'(p4_out & p4_oe), 32'h30);
    apb(1'b0, 12'h074, 32'h0);
    chk(got, 32'h35);
    apb(1'b1, 12'h030, 32'hFFFF);
    apb(1'b0, 12'h030, 32'h0);
    chk(got, 32'h0);
    apb(1'b1, 12'h08C, 32'hFFFF);
    apb(1'b0, 12'h08C, 32'h0);
    chk(got, 32'h0);
    apb(1'b0, 12'h094, 32'h0);
    chk(got, 32'h2AAA);
    apb(1'b1, 12'h054, 32'h1);
    chk(32'(got_err), 32'h1);
    apb(1'b0, 12'h104, 32'h0);
    chk(32'(got_err), 32'h1);
    apb(1'b0, 12'h002, 32'h0);
    chk(32'(got_err), 32'h1);
    $display("test drive mode done");
    apb(1'b1, 12'h03C, 32'h0E);
    apb(1'b1, 12'h05C, 32'h3B);
    apb(1'b1, 12'h07C, 32'h1F);
    wt(2);
    chk(32'(pad_output_control[11:4]), 32'hBE);
    chk(32'(input_threshold[3:0]), 32'h7);
    apb(1'b1, 12'h040, 32'h3);
    apb(1'b1, 12'h04C, 32'h2);
    apb(1'b1, 12'h058, 32'h1);
    wt(2);
    chk(32'(p3_oe), 32'h3);
    chk(32'(p3_out & p3_oe), 32'h2);
    $display("test pad and alternate done");
    // Port 4 back to push/pull so segment lines show in full
    apb(1'b1, 12'h070, 32'h0);
    ebc_active <= 1'b1;
    ebc_mux <= 1'b1;
    ebc_addr_phase <= 1'b1;
    ebc_addr <= 16'h1234;
    ebc_rd_n <= 1'b0;
    ebc_ale <= 1'b1;
    wt(2);
    chk(32'(p0_out), 32'h1234);
    chk(32'(p20_out[2:0]), 32'h6);
    ebc_mux <= 1'b0;
    ebc_addr_phase <= 1'b0;
    ebc_wdata_oe <= 1'b1;
    ebc_wdata <= 16'hBEEF;
    ebc_seg_en <= 1'b1;
    ebc_seg <= 8'hC3;
    wt(2);
    chk({p1_out, p0_out}, 32'h1234BEEF);
    chk(32'(p4_out), 32'hC3);
    ebc_cs_n <= 4'hA;
    apb(1'b1, 12'h100, 32'h4);
    wt(2);
    chk(32'(p4_out[7:4]), 32'hA);
    ebc_active <= 1'b0;
    $display("test bus done");
    p4_ext <= 8'h10;
    p4_ext_en <= 8'h50;
    apb(1'b1, 12'h100, 32'h2);
    // Pad edge, two sync stages and the receive flop
    wt(5);
    chk(32'({p4_out[7], p4_out[5], can_rx}), 32'h9);
    apb(1'b1, 12'h100, 32'h3);
    wt(4);
    chk(32'({p9_out[3], p9_out[1], can_rx}), 32'hA);
    apb(1'b1, 12'h100, 32'h0);
    wt(4);
    chk(32'(can_rx), 32'h3);
    $display("test can done");
    reset_request <= 1'b1;
    p20_in <= 5'h08;
    wt(2);
    chk(32'(p20_out[4]), 32'h0);
    reset_request <= 1'b0;
    wt(5);
    chk(32'({p20_out[4], external_access_enable}), 32'h3);
    rst_n <= 1'b0;
    wt(2);
    chk(32'(p20_oe), 32'h10);
    chk(32'(p0_oe | p3_oe | p4_oe | p9_oe), 32'h0);
    rst_n <= 1'b1;
    wt(2);
    $display("test reset done");
    final_report();
  end
endmodule
